// ===== design/xmalu_pkg.sv
// constants, opcodes and register map of the extended memory alu block
// Notes on behaviour
// - operands are addressed by a full data-memory address, no bank select used.
// - store_accumulator copies accumulator into memory byte, flags kept.
// - or_into_accumulator puts acc OR byte into accumulator, only zero flag changes.
// - or_into_memory writes acc OR byte back to memory, only zero flag changes.
// - rotate_left_byte moves bits up one, bit 7 into bit 0, flags kept.
// - rotate left via carry loads old carry into bit 0, old bit 7 into carry.
// - rotate_right_byte moves bits down one, bit 0 into bit 7, flags kept.
// - rotate right via carry loads old carry into bit 7, old bit 0 into carry.
// - accumulator rotate forms write only the accumulator; carry forms still update carry.
// - subtract with borrow computes acc minus byte minus inverted carry, to acc or memory.
// - plain subtract computes acc minus byte and updates the six arithmetic flags.
// - after any subtraction carry is 0 for negative, 1 for zero or positive.
// - decrement_skip_zero writes byte minus one to memory, skips when that is zero.
// - increment_skip_zero writes byte plus one to memory, skips when that is zero.
// - accumulator forms of these write only the accumulator and skip on its zero.
// - skipping instructions take four cycles, the last a dummy cycle, and alter no flags.
// - set_bits byte form writes all ones to the memory byte, flags kept.
// - set_bits bit form forces the chosen bit to one, other bits and flags kept.
// - bit form of skip_if_nonzero skips when the chosen bit is one.
// - byte form of skip_if_nonzero skips when the whole byte is nonzero.
// - nibble_exchange swaps the two nibbles of the memory byte in place, flags kept.
package xmalu_pkg;

	// operation codes presented by the instruction sequencer
	localparam int             OP_W                          = 5;
	localparam logic [OP_W-1:0] OP_STORE_ACCUMULATOR          = 5'h00;
	localparam logic [OP_W-1:0] OP_OR_INTO_ACCUMULATOR        = 5'h01;
	localparam logic [OP_W-1:0] OP_OR_INTO_MEMORY             = 5'h02;
	localparam logic [OP_W-1:0] OP_ROTATE_LEFT_BYTE           = 5'h03;
	localparam logic [OP_W-1:0] OP_ROTATE_LEFT_TO_ACC         = 5'h04;
	localparam logic [OP_W-1:0] OP_ROTATE_LEFT_VIA_CARRY      = 5'h05;
	localparam logic [OP_W-1:0] OP_ROTATE_LEFT_VIA_CARRY_ACC  = 5'h06;
	localparam logic [OP_W-1:0] OP_ROTATE_RIGHT_BYTE          = 5'h07;
	localparam logic [OP_W-1:0] OP_ROTATE_RIGHT_TO_ACC        = 5'h08;
	localparam logic [OP_W-1:0] OP_ROTATE_RIGHT_VIA_CARRY     = 5'h09;
	localparam logic [OP_W-1:0] OP_ROTATE_RIGHT_VIA_CARRY_ACC = 5'h0A;
	localparam logic [OP_W-1:0] OP_SUBTRACT_BORROW_TO_ACC     = 5'h0B;
	localparam logic [OP_W-1:0] OP_SUBTRACT_BORROW_TO_MEMORY  = 5'h0C;
	localparam logic [OP_W-1:0] OP_SUBTRACT_TO_ACC            = 5'h0D;
	localparam logic [OP_W-1:0] OP_SUBTRACT_TO_MEMORY         = 5'h0E;
	localparam logic [OP_W-1:0] OP_DECREMENT_SKIP_ZERO        = 5'h0F;
	localparam logic [OP_W-1:0] OP_DECREMENT_SKIP_ZERO_TO_ACC = 5'h10;
	localparam logic [OP_W-1:0] OP_INCREMENT_SKIP_ZERO        = 5'h11;
	localparam logic [OP_W-1:0] OP_INCREMENT_SKIP_ZERO_TO_ACC = 5'h12;
	localparam logic [OP_W-1:0] OP_SET_BITS_BYTE              = 5'h13;
	localparam logic [OP_W-1:0] OP_SET_BITS_BIT               = 5'h14;
	localparam logic [OP_W-1:0] OP_SKIP_IF_NONZERO_BYTE       = 5'h15;
	localparam logic [OP_W-1:0] OP_SKIP_IF_NONZERO_BIT        = 5'h16;
	localparam logic [OP_W-1:0] OP_NIBBLE_EXCHANGE            = 5'h17;

	// avalon byte offsets of the three registers
	localparam int         AV_ADDR_W    = 4;
	localparam logic [3:0] REG_ACC      = 4'h0;
	localparam logic [3:0] REG_STATUS   = 4'h4;
	localparam logic [3:0] REG_INFO     = 4'h8;

	// status register bit positions
	localparam int FLAG_CARRY  = 0;
	localparam int FLAG_NIBBLE = 1;
	localparam int FLAG_ZERO   = 2;
	localparam int FLAG_WRAP   = 3;
	localparam int FLAG_SIGNED = 4;
	localparam int FLAG_CHAIN  = 5;
	localparam int FLAG_W      = 6;

	// info register bit positions
	localparam int INFO_BUSY = 0;
	localparam int INFO_SKIP = 1;

	// reset values and byte constants
	localparam logic [7:0]        ACC_RESET    = 8'h00;
	localparam logic [FLAG_W-1:0] FLAGS_RESET  = 6'h00;
	localparam logic [7:0]        BYTE_ONES    = 8'hFF;
	localparam logic [7:0]        BYTE_ZERO    = 8'h00;
	localparam logic [7:0]        BYTE_ONE     = 8'h01;

endpackage : xmalu_pkg

// ===== design/xmalu_core.sv
// extended memory alu: sequencer handshake, data-memory port and avalon registers
//
// Added by the designer: the address map and the Avalon-MM register port.
`timescale 1ns/100ps
module xmalu_core #(
	parameter int MEM_ADDR_W = 12
) (
	// clock and reset
	input  wire logic                         mclk,
	input  wire logic                         reset,
	// instruction sequencer request
	input  wire logic                         opValid,
	input  wire logic [xmalu_pkg::OP_W-1:0]   opCode,
	input  wire logic [MEM_ADDR_W-1:0]        opAddr,
	input  wire logic [2:0]                   opBit,
	output logic                              opReady,
	// instruction sequencer answer
	output logic                              opDone,
	output logic                              opSkip,
	output logic                              opDummy,
	// data memory port, read data one cycle after memRdEn
	output logic [MEM_ADDR_W-1:0]             memAddr,
	output logic                              memRdEn,
	input  wire logic [7:0]                   memRdData,
	output logic                              memWrEn,
	output logic [7:0]                        memWrData,
	// avalon-mm slave
	input  wire logic [xmalu_pkg::AV_ADDR_W-1:0] address,
	input  wire logic                         read,
	input  wire logic                         write,
	input  wire logic [31:0]                  writedata,
	input  wire logic [3:0]                   byteenable,
	output logic [31:0]                       readdata,
	output logic                              waitrequest,
	// architectural state seen by the core
	output logic [7:0]                        accOut,
	output logic [xmalu_pkg::FLAG_W-1:0]      flagsOut
);

	// refuse address widths the memory port cannot serve, at elaboration
	if (MEM_ADDR_W < 8 || MEM_ADDR_W > 24)
	begin : g_badAddrWidth
		$error("xmalu_core: MEM_ADDR_W must lie in 8..24");
	end

	typedef enum logic [2:0] {ST_IDLE, ST_READ, ST_CALC, ST_WRITE, ST_DUMMY} xmalu_state_e;

	// one-hot mask of a single bit
	function automatic logic [7:0] bitMask(input logic [2:0] idx);
		logic [7:0] m;
		m = xmalu_pkg::BYTE_ONE << idx;
		return m;
	endfunction : bitMask

	// 9-bit difference, msb is the borrow out
	function automatic logic [8:0] sub9(input logic [7:0] a, input logic [7:0] b,
		input logic bin);
		logic [8:0] d;
		d = {1'b0, a} - {1'b0, b} - {8'h00, bin};
		return d;
	endfunction : sub9

	xmalu_state_e                  state_r;
	xmalu_state_e                  state_nxt;
	logic [xmalu_pkg::OP_W-1:0]    code_r;
	logic [MEM_ADDR_W-1:0]         addr_r;
	logic [2:0]                    bit_r;
	logic [7:0]                    acc_r;
	logic [xmalu_pkg::FLAG_W-1:0]  flags_r;
	logic [7:0]                    res_r;
	logic                          wrMem_r;
	logic                          skip_r;
	logic                          lastSkip_r;
	logic                          ack_r;
	logic [31:0]                   rdData_r;

	// combinational results of the calc cycle
	logic [7:0]                    resNxt;
	logic                          wrMemNxt;
	logic                          wrAccNxt;
	logic                          skipNxt;
	logic [xmalu_pkg::FLAG_W-1:0]  flagsNxt;

	// operand aliases
	wire logic [7:0] mByte = memRdData;
	wire logic       cIn   = flags_r[xmalu_pkg::FLAG_CARRY];

	// rotate results
	wire logic [7:0] rotL  = {mByte[6:0], mByte[7]};
	wire logic [7:0] rotLC = {mByte[6:0], cIn};
	wire logic [7:0] rotR  = {mByte[0], mByte[7:1]};
	wire logic [7:0] rotRC = {cIn, mByte[7:1]};

	// subtractor shared by the four subtract forms
	wire logic       isBorrowOp = (code_r == xmalu_pkg::OP_SUBTRACT_BORROW_TO_ACC) ||
		(code_r == xmalu_pkg::OP_SUBTRACT_BORROW_TO_MEMORY);
	wire logic       borrowIn   = isBorrowOp & ~cIn;
	wire logic [8:0] diff       = sub9(acc_r, mByte, borrowIn);
	wire logic [8:0] diffLow    = sub9({4'h0, acc_r[3:0]}, {4'h0, mByte[3:0]}, borrowIn);
	wire logic [7:0] diffByte   = diff[7:0];
	wire logic       diffZero   = (diffByte == xmalu_pkg::BYTE_ZERO);
	wire logic       diffWrap   = (acc_r[7] ^ mByte[7]) & (acc_r[7] ^ diffByte[7]);

	// subtract flag set; chained zero only holds across a borrow chain
	logic [xmalu_pkg::FLAG_W-1:0] subFlags;
	always_comb
	begin
		subFlags                          = flags_r;
		subFlags[xmalu_pkg::FLAG_CARRY]   = ~diff[8];
		subFlags[xmalu_pkg::FLAG_NIBBLE]  = ~diffLow[4];
		subFlags[xmalu_pkg::FLAG_ZERO]    = diffZero;
		subFlags[xmalu_pkg::FLAG_WRAP]    = diffWrap;
		subFlags[xmalu_pkg::FLAG_SIGNED]  = diffWrap ^ diffByte[7];
		subFlags[xmalu_pkg::FLAG_CHAIN]   = isBorrowOp ?
			(diffZero & flags_r[xmalu_pkg::FLAG_CHAIN]) : diffZero;
	end

	// increment, decrement and or results
	wire logic [7:0] decByte = mByte - xmalu_pkg::BYTE_ONE;
	wire logic [7:0] incByte = mByte + xmalu_pkg::BYTE_ONE;
	wire logic [7:0] orByte  = acc_r | mByte;
	wire logic       orZero  = (orByte == xmalu_pkg::BYTE_ZERO);

	// operation decode; every path starts from the held flags
	always_comb
	begin
		resNxt   = mByte;
		wrMemNxt = 1'b0;
		wrAccNxt = 1'b0;
		skipNxt  = 1'b0;
		flagsNxt = flags_r;
		case (code_r)
			xmalu_pkg::OP_STORE_ACCUMULATOR:
			begin
				resNxt   = acc_r;
				wrMemNxt = 1'b1;
			end
			xmalu_pkg::OP_OR_INTO_ACCUMULATOR:
			begin
				resNxt   = orByte;
				wrAccNxt = 1'b1;
				flagsNxt[xmalu_pkg::FLAG_ZERO] = orZero;
			end
			xmalu_pkg::OP_OR_INTO_MEMORY:
			begin
				resNxt   = orByte;
				wrMemNxt = 1'b1;
				flagsNxt[xmalu_pkg::FLAG_ZERO] = orZero;
			end
			xmalu_pkg::OP_ROTATE_LEFT_BYTE:
			begin
				resNxt   = rotL;
				wrMemNxt = 1'b1;
			end
			xmalu_pkg::OP_ROTATE_LEFT_TO_ACC:
			begin
				resNxt   = rotL;
				wrAccNxt = 1'b1;
			end
			xmalu_pkg::OP_ROTATE_LEFT_VIA_CARRY:
			begin
				resNxt   = rotLC;
				wrMemNxt = 1'b1;
				flagsNxt[xmalu_pkg::FLAG_CARRY] = mByte[7];
			end
			xmalu_pkg::OP_ROTATE_LEFT_VIA_CARRY_ACC:
			begin
				resNxt   = rotLC;
				wrAccNxt = 1'b1;
				flagsNxt[xmalu_pkg::FLAG_CARRY] = mByte[7];
			end
			xmalu_pkg::OP_ROTATE_RIGHT_BYTE:
			begin
				resNxt   = rotR;
				wrMemNxt = 1'b1;
			end
			xmalu_pkg::OP_ROTATE_RIGHT_TO_ACC:
			begin
				resNxt   = rotR;
				wrAccNxt = 1'b1;
			end
			xmalu_pkg::OP_ROTATE_RIGHT_VIA_CARRY:
			begin
				resNxt   = rotRC;
				wrMemNxt = 1'b1;
				flagsNxt[xmalu_pkg::FLAG_CARRY] = mByte[0];
			end
			xmalu_pkg::OP_ROTATE_RIGHT_VIA_CARRY_ACC:
			begin
				resNxt   = rotRC;
				wrAccNxt = 1'b1;
				flagsNxt[xmalu_pkg::FLAG_CARRY] = mByte[0];
			end
			xmalu_pkg::OP_SUBTRACT_BORROW_TO_ACC, xmalu_pkg::OP_SUBTRACT_TO_ACC:
			begin
				resNxt   = diffByte;
				wrAccNxt = 1'b1;
				flagsNxt = subFlags;
			end
			xmalu_pkg::OP_SUBTRACT_BORROW_TO_MEMORY, xmalu_pkg::OP_SUBTRACT_TO_MEMORY:
			begin
				resNxt   = diffByte;
				wrMemNxt = 1'b1;
				flagsNxt = subFlags;
			end
			xmalu_pkg::OP_DECREMENT_SKIP_ZERO:
			begin
				resNxt   = decByte;
				wrMemNxt = 1'b1;
				skipNxt  = (decByte == xmalu_pkg::BYTE_ZERO);
			end
			xmalu_pkg::OP_DECREMENT_SKIP_ZERO_TO_ACC:
			begin
				resNxt   = decByte;
				wrAccNxt = 1'b1;
				skipNxt  = (decByte == xmalu_pkg::BYTE_ZERO);
			end
			xmalu_pkg::OP_INCREMENT_SKIP_ZERO:
			begin
				resNxt   = incByte;
				wrMemNxt = 1'b1;
				skipNxt  = (incByte == xmalu_pkg::BYTE_ZERO);
			end
			xmalu_pkg::OP_INCREMENT_SKIP_ZERO_TO_ACC:
			begin
				resNxt   = incByte;
				wrAccNxt = 1'b1;
				skipNxt  = (incByte == xmalu_pkg::BYTE_ZERO);
			end
			xmalu_pkg::OP_SET_BITS_BYTE:
			begin
				resNxt   = xmalu_pkg::BYTE_ONES;
				wrMemNxt = 1'b1;
			end
			xmalu_pkg::OP_SET_BITS_BIT:
			begin
				resNxt   = mByte | bitMask(bit_r);
				wrMemNxt = 1'b1;
			end
			xmalu_pkg::OP_SKIP_IF_NONZERO_BYTE:
				skipNxt  = (mByte != xmalu_pkg::BYTE_ZERO);
			xmalu_pkg::OP_SKIP_IF_NONZERO_BIT:
				skipNxt  = |(mByte & bitMask(bit_r));
			xmalu_pkg::OP_NIBBLE_EXCHANGE:
			begin
				resNxt   = {mByte[3:0], mByte[7:4]};
				wrMemNxt = 1'b1;
			end
			default:
			begin
				resNxt   = mByte;
				skipNxt  = 1'b0;
			end
		endcase
	end

	// avalon decode; a bus write waits while an operation is in flight
	wire logic idle      = (state_r == ST_IDLE);
	wire logic busReq    = read | write;
	wire logic busReady  = ~write | idle;
	wire logic busCommit = busReq & ack_r;
	wire logic busWrAcc  = busCommit & write & (address == xmalu_pkg::REG_ACC) & byteenable[0];
	wire logic busWrStat = busCommit & write & (address == xmalu_pkg::REG_STATUS) &
		byteenable[0];
	wire logic startOp   = opValid & opReady;

	// bus word images
	logic [31:0] rdImage;
	always_comb
	begin
		rdImage = 32'h0000_0000;
		case (address)
			xmalu_pkg::REG_ACC:    rdImage[7:0] = acc_r;
			xmalu_pkg::REG_STATUS: rdImage[xmalu_pkg::FLAG_W-1:0] = flags_r;
			xmalu_pkg::REG_INFO:
			begin
				rdImage[xmalu_pkg::INFO_BUSY] = ~idle;
				rdImage[xmalu_pkg::INFO_SKIP] = lastSkip_r;
			end
			default:               rdImage = 32'h0000_0000;
		endcase
	end

	// handshake outputs; a bus write in its commit cycle holds off a new op
	assign opReady     = idle & ~(write & ack_r);
	assign opDone      = ((state_r == ST_WRITE) & ~skip_r) | (state_r == ST_DUMMY);
	assign opSkip      = (state_r == ST_DUMMY);
	assign opDummy     = (state_r == ST_DUMMY);
	assign memRdEn     = (state_r == ST_READ);
	assign memAddr     = addr_r;
	assign memWrEn     = (state_r == ST_WRITE) & wrMem_r;
	assign memWrData   = res_r;
	assign waitrequest = busReq & ~ack_r;
	assign readdata    = rdData_r;
	assign accOut      = acc_r;
	assign flagsOut    = flags_r;

	// sequence: read, calc, write, then a dummy cycle when skipping
	always_comb
	begin
		state_nxt = state_r;
		case (state_r)
			ST_IDLE:  state_nxt = startOp ? ST_READ : ST_IDLE;
			ST_READ:  state_nxt = ST_CALC;
			ST_CALC:  state_nxt = ST_WRITE;
			ST_WRITE: state_nxt = skip_r ? ST_DUMMY : ST_IDLE;
			ST_DUMMY: state_nxt = ST_IDLE;
			default:  state_nxt = ST_IDLE;
		endcase
	end

	// state and captured request
	always_ff @(posedge mclk or posedge reset)
	begin
		if (reset)
		begin
			state_r <= ST_IDLE;
			code_r  <= xmalu_pkg::OP_STORE_ACCUMULATOR;
			addr_r  <= '0;
			bit_r   <= 3'h0;
		end
		else
		begin
			state_r <= state_nxt;
			if (startOp)
			begin
				code_r <= opCode;
				addr_r <= opAddr;
				bit_r  <= opBit;
			end
		end
	end

	// results latched at calc; skip never touches flags beyond flagsNxt
	always_ff @(posedge mclk or posedge reset)
	begin
		if (reset)
		begin
			res_r      <= xmalu_pkg::BYTE_ZERO;
			wrMem_r    <= 1'b0;
			skip_r     <= 1'b0;
			lastSkip_r <= 1'b0;
		end
		else if (state_r == ST_CALC)
		begin
			res_r      <= resNxt;
			wrMem_r    <= wrMemNxt;
			skip_r     <= skipNxt;
			lastSkip_r <= skipNxt;
		end
	end

	// accumulator and flags: op results, else a software write when idle
	always_ff @(posedge mclk or posedge reset)
	begin
		if (reset)
		begin
			acc_r   <= xmalu_pkg::ACC_RESET;
			flags_r <= xmalu_pkg::FLAGS_RESET;
		end
		else if (state_r == ST_CALC)
		begin
			if (wrAccNxt)
				acc_r <= resNxt;
			flags_r <= flagsNxt;
		end
		else
		begin
			if (busWrAcc)
				acc_r <= writedata[7:0];
			if (busWrStat)
				flags_r <= writedata[xmalu_pkg::FLAG_W-1:0];
		end
	end

	// bus answer one cycle after the request, later for writes while busy
	always_ff @(posedge mclk or posedge reset)
	begin
		if (reset)
		begin
			ack_r    <= 1'b0;
			rdData_r <= 32'h0000_0000;
		end
		else
		begin
			ack_r    <= busReq & ~ack_r & busReady;
			rdData_r <= read ? rdImage : 32'h0000_0000;
		end
	end

endmodule : xmalu_core

// ===== testbench/xmalu_monitor.sv
// concurrent checks on the sequencer and memory ports of the alu
`timescale 1ns/100ps
module xmalu_monitor #(
	parameter int MEM_ADDR_W = 12
) (
	// clock and reset
	input wire logic                  mclk,
	input wire logic                  reset,
	// sequencer side
	input wire logic                  opValid,
	input wire logic [4:0]            opCode,
	input wire logic [MEM_ADDR_W-1:0] opAddr,
	input wire logic                  opReady,
	input wire logic                  opDone,
	input wire logic                  opSkip,
	input wire logic                  opDummy,
	// memory side and state
	input wire logic [MEM_ADDR_W-1:0] memAddr,
	input wire logic                  memRdEn,
	input wire logic [7:0]            memRdData,
	input wire logic                  memWrEn,
	input wire logic [7:0]            memWrData,
	input wire logic [7:0]            accOut,
	input wire logic [5:0]            flagsOut
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (reset);
	logic tk;
	// request taken this cycle
	assign tk = opValid && opReady;
	sequence s_calc(logic [4:0] c); tk && opCode == c ##2 1'b1; endsequence
	property p_read; tk |=> memRdEn && memAddr == $past(opAddr); endproperty
	a_read: assert property (p_read) else $error("operand read wrong");
	property p_lat; tk |=> !opDone [*2] ##1 (opDone or !opDone ##1 (opDone && opSkip)); endproperty
	a_lat: assert property (p_lat) else $error("done timing wrong");
	property p_skip; opSkip |-> opDone && opDummy && flagsOut == $past(flagsOut, 3); endproperty
	a_skip: assert property (p_skip) else $error("skip slot wrong");
	property p_store;
		tk && opCode == xmalu_pkg::OP_STORE_ACCUMULATOR |-> ##3 memWrEn && memWrData == accOut
			&& flagsOut == $past(flagsOut, 3);
	endproperty
	a_store: assert property (p_store) else $error("store wrong");
	property p_set;
		tk && opCode == xmalu_pkg::OP_SET_BITS_BYTE |-> ##3 memWrEn && memWrData == 8'hFF;
	endproperty
	a_set: assert property (p_set) else $error("set byte wrong");
	property p_rotl;
		s_calc(xmalu_pkg::OP_ROTATE_LEFT_BYTE) |=> memWrEn
			&& memWrData == {$past(memRdData[6:0]), $past(memRdData[7])}
			&& flagsOut == $past(flagsOut, 3);
	endproperty
	a_rotl: assert property (p_rotl) else $error("rotate left wrong");
	property p_swap;
		s_calc(xmalu_pkg::OP_NIBBLE_EXCHANGE) |=> memWrEn
			&& memWrData == {$past(memRdData[3:0]), $past(memRdData[7:4])};
	endproperty
	a_swap: assert property (p_swap) else $error("swap wrong");
	property p_accrot;
		tk && (opCode == xmalu_pkg::OP_ROTATE_LEFT_TO_ACC
			|| opCode == xmalu_pkg::OP_ROTATE_RIGHT_VIA_CARRY_ACC) |=> !memWrEn [*4];
	endproperty
	a_accrot: assert property (p_accrot) else $error("acc rotate wrote memory");
	property p_orm;
		s_calc(xmalu_pkg::OP_OR_INTO_MEMORY) |=> memWrEn && memWrData == ($past(memRdData) | accOut);
	endproperty
	a_orm: assert property (p_orm) else $error("or into memory wrong");
	c_skip: cover property (opSkip);
	c_store: cover property (tk && opCode == xmalu_pkg::OP_STORE_ACCUMULATOR);
	c_orm: cover property (s_calc(xmalu_pkg::OP_OR_INTO_MEMORY));
endmodule : xmalu_monitor

// ===== testbench/xmalu_mem_model.sv
// data memory behind the alu operand port
`timescale 1ns/100ps
module xmalu_mem_model #(
	parameter int MEM_ADDR_W = 8
) (
	// clock
	input wire logic                  mclk,
	// operand port
	input wire logic [MEM_ADDR_W-1:0] memAddr,
	input wire logic                  memRdEn,
	output logic [7:0]                memRdData,
	input wire logic                  memWrEn,
	input wire logic [7:0]            memWrData
);
	logic [7:0] mem [1<<MEM_ADDR_W];
	initial memRdData = 8'h00;
	// one-cycle read; outside a read slot data toggles so a stale byte never looks valid
	always @(posedge mclk)
	begin
		if (memWrEn)
			mem[memAddr] <= memWrData;
		memRdData <= memRdEn ? mem[memAddr] : ~memRdData;
	end
endmodule : xmalu_mem_model

// ===== testbench/test_extended_memory_alu_ops.sv
// self-checking bench of the extended memory alu with a reference model
`timescale 1ns/100ps
module test_extended_memory_alu_ops;
	localparam int          AW   = 8;
	localparam logic [23:0] MEMT = 24'h9AD2AD; // codes with a memory result
	localparam logic [23:0] ACCT = 24'h052D52; // codes with an accumulator result
	logic          mclk = 1'b0, reset = 1'b1, opValid = 1'b0, read = 1'b0, write = 1'b0;
	logic [4:0]    opCode = 5'h00;
	logic [AW-1:0] opAddr = 8'h00, memAddr;
	logic [2:0]    opBit = 3'h0;
	logic          opReady, opDone, opSkip, opDummy, memRdEn, memWrEn, waitrequest, ls;
	logic [7:0]    memRdData, memWrData, accOut, acc;
	logic [5:0]    flagsOut, flg;
	logic [3:0]    address = 4'h0, byteenable = 4'hF;
	logic [31:0]   writedata = 32'h00000000, readdata, q;
	logic [7:0]    shadow [256];
	int            fails = 0, checked = 0, cyc = 0, seed = 32'hC3CC89C4;
	always #10 mclk = ~mclk;
	xmalu_core #(.MEM_ADDR_W(AW)) i_xmalu_core (.mclk(mclk), .reset(reset), .opValid(opValid),
		.opCode(opCode), .opAddr(opAddr), .opBit(opBit), .opReady(opReady), .opDone(opDone),
		.opSkip(opSkip), .opDummy(opDummy), .memAddr(memAddr), .memRdEn(memRdEn),
		.memRdData(memRdData), .memWrEn(memWrEn), .memWrData(memWrData), .address(address),
		.read(read), .write(write), .writedata(writedata), .byteenable(byteenable),
		.readdata(readdata), .waitrequest(waitrequest), .accOut(accOut), .flagsOut(flagsOut));
	xmalu_mem_model #(.MEM_ADDR_W(AW)) i_xmalu_mem_model (.mclk(mclk), .memAddr(memAddr),
		.memRdEn(memRdEn), .memRdData(memRdData), .memWrEn(memWrEn), .memWrData(memWrData));
	// hang guard, far above the few thousand cycles the run needs
	always @(posedge mclk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			fails++;
			conclude();
		end
	end
	task automatic conclude();
		if (fails == 0 && checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : conclude
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp)
		begin
			fails++;
			$display("ERROR at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	// avalon transfer held until waitrequest is sampled low; model follows accepted writes
	task automatic bus(input logic w, input logic [3:0] ad, input logic [31:0] d,
		input logic [3:0] be);
		read <= !w;
		write <= w;
		address <= ad;
		writedata <= d;
		byteenable <= be;
		@(posedge mclk);
		while (waitrequest !== 1'b0)
			@(posedge mclk);
		q = readdata;
		read <= 1'b0;
		write <= 1'b0;
		if (w && be[0] && ad == 4'h0)
			acc = d[7:0];
		if (w && be[0] && ad == 4'h4)
			flg = d[5:0];
		@(posedge mclk);
	endtask : bus
	task automatic put(input logic [7:0] a, input logic [7:0] v);
		i_xmalu_mem_model.mem[a] = v;
		shadow[a] = v;
	endtask : put
	// predict one operation, run it through the handshake, then compare everything
	task automatic op(input logic [4:0] c, input logic [7:0] a, input logic [2:0] b);
		logic [7:0] m, r;
		logic [8:0] d;
		logic [4:0] n;
		logic       sk, bw, c0;
		int         k;
		m = shadow[a];
		r = m;
		c0 = flg[0];
		sk = 1'b0;
		bw = (c == 5'h0B || c == 5'h0C) && !c0;
		d = {1'b0, acc} - {1'b0, m} - 9'(bw);
		n = {1'b0, acc[3:0]} - {1'b0, m[3:0]} - 5'(bw);
		case (c)
			5'h00: r = acc;
			5'h01, 5'h02: r = acc | m;
			5'h03, 5'h04: r = {m[6:0], m[7]};
			5'h05, 5'h06: r = {m[6:0], c0};
			5'h07, 5'h08: r = {m[0], m[7:1]};
			5'h09, 5'h0A: r = {c0, m[7:1]};
			5'h0B, 5'h0C, 5'h0D, 5'h0E: r = d[7:0];
			5'h0F, 5'h10: r = m - 8'h01;
			5'h11, 5'h12: r = m + 8'h01;
			5'h13: r = 8'hFF;
			5'h14: r = m | (8'h01 << b);
			5'h15: sk = (m != 8'h00);
			5'h16: sk = m[b];
			default: r = {m[3:0], m[7:4]};
		endcase
		if (c >= 5'h0F && c <= 5'h12)
			sk = (r == 8'h00);
		if (c == 5'h01 || c == 5'h02)
			flg[2] = (r == 8'h00);
		if (c >= 5'h05 && c <= 5'h0A && c != 5'h07 && c != 5'h08)
			flg[0] = (c < 5'h07) ? m[7] : m[0];
		if (c >= 5'h0B && c <= 5'h0E)
			flg = {(r == 8'h00) && (c > 5'h0C || flg[5]), ((acc[7] != m[7]) && (r[7] != acc[7]))
				^ r[7], (acc[7] != m[7]) && (r[7] != acc[7]), r == 8'h00, !n[4], !d[8]};
		if (MEMT[c])
			shadow[a] = r;
		if (ACCT[c])
			acc = r;
		ls = sk;
		opValid <= 1'b1;
		opCode <= c;
		opAddr <= a;
		opBit <= b;
		@(posedge mclk);
		while (opReady !== 1'b1)
			@(posedge mclk);
		opValid <= 1'b0;
		k = 0;
		while (k < 6 && (k == 0 || opDone !== 1'b1))
		begin
			@(posedge mclk);
			k++;
		end
		chk(k, sk ? 4 : 3);
		chk(opSkip, sk);
		@(posedge mclk);
		chk(accOut, acc);
		chk(flagsOut, flg);
		chk(i_xmalu_mem_model.mem[a], shadow[a]);
	endtask : op
	initial
	begin
		acc = 8'h00;
		flg = 6'h00;
		for (int i = 0; i < 256; i++)
			put(8'(i), 8'($random(seed)));
		repeat (2) @(posedge mclk);
		reset <= 1'b0;
		@(posedge mclk);
		chk(flagsOut, 6'h00);
		bus(1'b0, 4'hC, 32'h0, 4'hF);
		chk(q, 32'h0);
		// every code once, then the wrap and zero corners of the counting forms
		for (int c = 0; c < 24; c++)
			op(5'(c), 8'($random(seed)), 3'($random(seed)));
		put(8'h10, 8'h01);
		op(5'h0F, 8'h10, 3'h0);
		put(8'h11, 8'hFF);
		op(5'h11, 8'h11, 3'h0);
		put(8'h12, 8'h01);
		op(5'h10, 8'h12, 3'h0);
		op(5'h12, 8'h11, 3'h0);
		op(5'h15, 8'h10, 3'h0);
		bus(1'b1, 4'h0, 32'h5A, 4'hF);
		put(8'h13, 8'h5A);
		op(5'h0D, 8'h13, 3'h0);
		repeat (300)
		begin
			if (2'($random(seed)) == 2'h0)
			begin
				bus(1'b1, 4'h0, $random(seed), 4'hF);
				bus(1'b1, 4'h4, $random(seed), 4'hF);
			end
			op(5'($unsigned($random(seed)) % 24), 8'($random(seed)), 3'($random(seed)));
		end
		bus(1'b1, 4'h0, 32'hA5, 4'h0);
		bus(1'b1, 4'hC, 32'hFF, 4'hF);
		bus(1'b0, 4'h0, 32'h0, 4'hF);
		chk(q, {24'h0, acc});
		bus(1'b0, 4'h4, 32'h0, 4'hF);
		chk(q, {26'h0, flg});
		bus(1'b0, 4'h8, 32'h0, 4'hF);
		chk(q, {30'h0, ls, 1'b0});
		conclude();
	end
endmodule : test_extended_memory_alu_ops
bind xmalu_core xmalu_monitor #(.MEM_ADDR_W(MEM_ADDR_W)) i_xmalu_monitor (.mclk(mclk),
	.reset(reset), .opValid(opValid), .opCode(opCode), .opAddr(opAddr), .opReady(opReady),
	.opDone(opDone), .opSkip(opSkip), .opDummy(opDummy), .memAddr(memAddr), .memRdEn(memRdEn),
	.memRdData(memRdData), .memWrEn(memWrEn), .memWrData(memWrData), .accOut(accOut),
	.flagsOut(flagsOut));
